/* File: dbgphy.v */
// Debug serial physical layer: two-wire link, scan communication register
`timescale 1ns/10ps
`default_nettype none
`include "dbgphy_defines.vh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Slow debug clock disables link, restores reset
// - Start low, eight data, parity, two high stops
// - Parity bit is even over data bits
// - Twelve low bits break, twelve high idle
// - Enabled link starts receiving, awaiting start bit
// - Change on falling edge, sample on rising
// - Transmit frames at link rate, idle fills gaps
// - Collision drops driver, receive mode awaits break
// - Collect eight bits, flag parity mismatch
// - Either stop bit low flags frame error
// - Deliver data only when parity, framing good
// - Break in receive recognised; in transmit collision
// - Receive to transmit inserts guard, minimum two
// - Drive only first cycle after value change, and first guard bit
// - Held bit compared with pin, mismatch collides
// - Scan path needs fuse set, disable clear
// - Comm instruction selects nine-bit comm register
// - Capture loads, shift on clock, update latches
// - Scan frame eight bits LSB first, parity

//////////////////////////////////////////////////////////////////////////////
// Transmit FIFO between the debug controller and the serialiser
module dbgphy_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             ref_clk_i,
	input  wire             rst_i,
	input  wire             ce_i,
	// Fill side
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	// Drain side
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW:0]      wr_ptr_r;
	reg [AW:0]      rd_ptr_r;
	wire            empty;
	wire            full;
	wire            push;
	wire            pop;

	// Extra pointer bit tells full from empty
	assign empty       = (wr_ptr_r == rd_ptr_r);
	assign full        = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) &&
	                     (wr_ptr_r[AW] != rd_ptr_r[AW]);
	assign in_ready_o  = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];
	assign push        = ce_i & in_valid_i & ~full;
	assign pop         = ce_i & out_ready_i & ~empty;

	// Storage has no reset; only the pointers need a defined value
	always @(posedge ref_clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
		end
	end

	// Pointer update
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

//////////////////////////////////////////////////////////////////////////////
// Physical layer top
module dbgphy #(
	parameter RST_MIN_CYC = 16'h0019,
	parameter IDLE_CYC    = `DBGPHY_IDLE_CYC,
	parameter FIFO_DEPTH  = 8,
	parameter FIFO_AW     = 3
) (
	// Clock, reset, enable
	input  wire       ref_clk_i,
	input  wire       rst_i,
	input  wire       ce_i,
	// Two-wire pins
	input  wire       debug_clock_pin_i,
	input  wire       debug_data_pin_i,
	output wire       debug_data_pin_o,
	output wire       debug_data_pin_oe_n_o,
	output wire       reset_pin_func_o,
	// Configuration
	input  wire       reset_fuse_off_i,
	input  wire [7:0] guard_bits_i,
	// Two-wire controller side
	output wire       link_en_o,
	output wire       tx_mode_o,
	input  wire       dir_tx_i,
	input  wire [7:0] tx_data_i,
	input  wire       tx_valid_i,
	output wire       tx_ready_o,
	output reg  [7:0] rx_data_o,
	output reg        rx_valid_o,
	output reg        par_err_o,
	output reg        frame_err_o,
	output reg        break_o,
	output reg        collision_o,
	// Scan path pins and tap state
	input  wire       scan_fuse_i,
	input  wire       scan_sw_dis_i,
	input  wire       scan_ir_comm_i,
	input  wire       scan_tck_i,
	input  wire       scan_tdi_i,
	input  wire       scan_capture_i,
	input  wire       scan_shift_i,
	input  wire       scan_update_i,
	output reg        scan_tdo_o,
	output wire       scan_en_o,
	// Scan path controller side
	input  wire [7:0] scan_cap_data_i,
	input  wire       scan_cap_valid_i,
	output reg  [7:0] scan_rx_data_o,
	output reg        scan_rx_valid_o,
	output reg        scan_par_err_o
);
	// Link modes
	localparam [3:0] M_OFF   = 4'h1;
	localparam [3:0] M_RX    = 4'h2;
	localparam [3:0] M_GUARD = 4'h4;
	localparam [3:0] M_TX    = 4'h8;
	// Receiver states
	localparam [4:0] R_IDLE  = 5'h01;
	localparam [4:0] R_DATA  = 5'h02;
	localparam [4:0] R_PAR   = 5'h04;
	localparam [4:0] R_SP1   = 5'h08;
	localparam [4:0] R_SP2   = 5'h10;
	localparam [15:0] IDLE_LIM = IDLE_CYC[15:0];

	// Even parity over a byte
	function par8;
		input [7:0] d;
		begin
			par8 = ^d;
		end
	endfunction

	reg  [7:0]  s1_r;
	reg  [7:0]  s2_r;
	reg  [7:0]  s3_r;
	reg  [3:0]  mode_r;
	reg         rstoff_r;
	reg  [15:0] hi_cnt_r;
	reg  [4:0]  en_cnt_r;
	reg  [15:0] idle_cnt_r;
	reg  [4:0]  rx_st_r;
	reg  [2:0]  rx_cnt_r;
	reg  [7:0]  rx_sh_r;
	reg         rx_par_r;
	reg         ferr_r;
	reg  [3:0]  low_run_r;
	reg         prev_hi_r;
	reg         wait_brk_r;
	reg  [7:0]  guard_cnt_r;
	reg  [10:0] tx_sh_r;
	reg  [3:0]  tx_left_r;
	reg         out_bit_r;
	reg         oe_n_r;
	reg         first_r;
	reg  [8:0]  scan_sh_r;
	wire        clk_rise;
	wire        clk_fall;
	wire        din;
	wire        timeout;
	wire        tck_rise;
	wire        tck_fall;
	wire        scan_act;
	wire        fifo_valid;
	wire [7:0]  fifo_data;
	wire        fifo_pop;
	wire        brk_now;
	wire        ferr_all;

	//////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers; only stage two and later are looked at
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// Debug clock and data rest high, so no false edge after reset
			s1_r <= 8'hC0;
			s2_r <= 8'hC0;
			s3_r <= 8'hC0;
		end else if (ce_i) begin
			s1_r <= {debug_clock_pin_i, debug_data_pin_i, scan_tck_i,
			         scan_tdi_i, scan_ir_comm_i, scan_capture_i,
			         scan_shift_i, scan_update_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign clk_rise = s2_r[7] & ~s3_r[7];
	assign clk_fall = ~s2_r[7] & s3_r[7];
	assign din      = s2_r[6];
	assign tck_rise = s2_r[5] & ~s3_r[5];
	assign tck_fall = ~s2_r[5] & s3_r[5];
	// A clock slower than the limit reads as a dead link
	assign timeout  = (idle_cnt_r >= IDLE_LIM);

	assign link_en_o             = ~mode_r[0];
	assign tx_mode_o             = mode_r[2] | mode_r[3];
	assign debug_data_pin_o      = out_bit_r;
	assign debug_data_pin_oe_n_o = oe_n_r;
	// Reset function is back while the link is off and the reset minimum has not yet passed, unless fused off
	assign reset_pin_func_o = ~reset_fuse_off_i & mode_r[0] & ~rstoff_r;

	// Characters are drawn only at a boundary, so the FIFO really fills
	assign fifo_pop = ce_i & mode_r[3] & clk_fall & (tx_left_r == 4'h0);
	// Twelfth low sample in a row
	assign brk_now  = ~din & (low_run_r == `DBGPHY_BRK_BITS - 4'h1);
	assign ferr_all = ferr_r | ~din;

	dbgphy_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) dbgphy_fifo_i (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_data_i   (tx_data_i),
		.in_valid_i  (tx_valid_i),
		.in_ready_o  (tx_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);

	//////////////////////////////////////////////////////////////////////////
	// Link state, receiver and transmitter
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_r      <= M_OFF;
			rstoff_r    <= 1'b0;
			hi_cnt_r    <= 16'h0000;
			en_cnt_r    <= 5'h00;
			idle_cnt_r  <= 16'h0000;
			rx_st_r     <= R_IDLE;
			rx_cnt_r    <= 3'h0;
			rx_sh_r     <= 8'h00;
			rx_par_r    <= 1'b0;
			ferr_r      <= 1'b0;
			low_run_r   <= 4'h0;
			prev_hi_r   <= 1'b0;
			wait_brk_r  <= 1'b0;
			guard_cnt_r <= 8'h00;
			tx_sh_r     <= 11'h7FF;
			tx_left_r   <= 4'h0;
			out_bit_r   <= 1'b1;
			oe_n_r      <= 1'b1;
			first_r     <= 1'b0;
			rx_data_o   <= 8'h00;
			rx_valid_o  <= 1'b0;
			par_err_o   <= 1'b0;
			frame_err_o <= 1'b0;
			break_o     <= 1'b0;
			collision_o <= 1'b0;
		end else if (ce_i) begin
			rx_valid_o  <= 1'b0;
			par_err_o   <= 1'b0;
			frame_err_o <= 1'b0;
			break_o     <= 1'b0;
			collision_o <= 1'b0;
			// Inactivity watch, restarted by any clock edge
			if (clk_rise | clk_fall | (mode_r[0] & ~rstoff_r)) begin
				idle_cnt_r <= 16'h0000;
			end else if (~timeout) begin
				idle_cnt_r <= idle_cnt_r + 16'h0001;
			end
			case (mode_r)
			M_OFF: begin
				// Enable: data high past reset minimum, then 16 clocks
				if (~din) begin
					rstoff_r <= 1'b0;
					hi_cnt_r <= 16'h0000;
					en_cnt_r <= 5'h00;
				end else if (~rstoff_r) begin
					hi_cnt_r <= hi_cnt_r + 16'h0001;
					if (hi_cnt_r == RST_MIN_CYC - 16'h0001) begin
						rstoff_r <= 1'b1;
					end
				end else if (timeout) begin
					rstoff_r <= 1'b0; // Too late, sequence starts over
					hi_cnt_r <= 16'h0000;
					en_cnt_r <= 5'h00;
				end else if (clk_rise) begin
					en_cnt_r <= en_cnt_r + 5'h01;
					if (en_cnt_r == `DBGPHY_EN_CLKS - 5'h01) begin
						mode_r     <= M_RX;
						rx_st_r    <= R_IDLE;
						wait_brk_r <= 1'b0;
						low_run_r  <= 4'h0;
						prev_hi_r  <= 1'b1;
						en_cnt_r   <= 5'h00;
					end
				end
			end
			M_RX: begin
				if (timeout) begin
					mode_r   <= M_OFF;
					rstoff_r <= 1'b0;
					hi_cnt_r <= 16'h0000;
				end else if (clk_rise) begin
					// Sample on the rising edge
					prev_hi_r <= din;
					if (din) begin
						low_run_r <= 4'h0;
					end else if (low_run_r != `DBGPHY_BRK_BITS) begin
						low_run_r <= low_run_r + 4'h1;
					end
					if (brk_now) begin
						break_o    <= 1'b1;
						wait_brk_r <= 1'b0;
						rx_st_r    <= R_IDLE;
					end else begin
						case (rx_st_r)
						R_IDLE: begin
							// Start only after a high bit, never mid-break
							if (~din & prev_hi_r & ~wait_brk_r) begin
								rx_st_r  <= R_DATA;
								rx_cnt_r <= 3'h0;
							end
						end
						R_DATA: begin
							rx_sh_r  <= {din, rx_sh_r[7:1]};
							rx_cnt_r <= rx_cnt_r + 3'h1;
							if (rx_cnt_r == 3'h7) begin
								rx_st_r <= R_PAR;
							end
						end
						R_PAR: begin
							rx_par_r <= din;
							rx_st_r  <= R_SP1;
						end
						R_SP1: begin
							ferr_r  <= ~din;
							rx_st_r <= R_SP2;
						end
						R_SP2: begin
							rx_st_r     <= R_IDLE;
							par_err_o   <= rx_par_r ^ par8(rx_sh_r);
							frame_err_o <= ferr_all;
							if (~ferr_all & (rx_par_r == par8(rx_sh_r))) begin
								rx_data_o  <= rx_sh_r;
								rx_valid_o <= 1'b1;
							end
						end
						default: begin
							rx_st_r <= R_IDLE;
						end
						endcase
					end
				end else if (dir_tx_i & rx_st_r[0] & ~wait_brk_r) begin
					// Never fewer than two guard bits
					mode_r      <= M_GUARD;
					first_r     <= 1'b1;
					guard_cnt_r <= (guard_bits_i < `DBGPHY_GUARD_MIN) ?
					               `DBGPHY_GUARD_MIN : guard_bits_i;
				end
			end
			M_GUARD, M_TX: begin
				if (timeout) begin
					mode_r   <= M_OFF;
					oe_n_r   <= 1'b1;
					rstoff_r <= 1'b0;
					hi_cnt_r <= 16'h0000;
				end else if (clk_rise & oe_n_r & ~first_r & (din != out_bit_r)) begin
					// Held bit read back wrong: someone else drives the pin
					collision_o <= 1'b1;
					mode_r      <= M_RX;
					oe_n_r      <= 1'b1;
					wait_brk_r  <= 1'b1;
					rx_st_r     <= R_IDLE;
					low_run_r   <= 4'h0;
					prev_hi_r   <= 1'b0;
					tx_left_r   <= 4'h0;
				end else if (clk_fall) begin
					// New bit goes out on the falling edge
					first_r <= 1'b0;
					if (mode_r[2]) begin
						out_bit_r   <= 1'b1;
						oe_n_r      <= ~(first_r | ~out_bit_r);
						guard_cnt_r <= guard_cnt_r - 8'h01;
						if (guard_cnt_r == 8'h01) begin
							mode_r <= M_TX;
						end
					end else if (tx_left_r != 4'h0) begin
						out_bit_r <= tx_sh_r[0];
						oe_n_r    <= ~(tx_sh_r[0] ^ out_bit_r);
						tx_sh_r   <= {1'b1, tx_sh_r[10:1]};
						tx_left_r <= tx_left_r - 4'h1;
					end else if (fifo_valid) begin
						// Frame: start, data LSB first, even parity, stops
						out_bit_r <= 1'b0;
						oe_n_r    <= ~out_bit_r;
						tx_sh_r   <= {2'b11, par8(fifo_data), fifo_data};
						tx_left_r <= `DBGPHY_FRAME_BITS - 4'h1;
					end else if (~dir_tx_i) begin
						mode_r    <= M_RX;
						oe_n_r    <= 1'b1;
						rx_st_r   <= R_IDLE;
						low_run_r <= 4'h0;
						prev_hi_r <= 1'b0;
					end else begin
						out_bit_r <= 1'b1;
						oe_n_r    <= out_bit_r;
					end
				end
			end
			default: begin
				mode_r <= M_OFF;
				oe_n_r <= 1'b1;
			end
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Scan path communication register, sampled from the tap clock
	assign scan_en_o = scan_fuse_i & ~scan_sw_dis_i;
	assign scan_act  = scan_en_o & s2_r[3];

	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scan_sh_r       <= 9'h000;
			scan_tdo_o      <= 1'b0;
			scan_rx_data_o  <= 8'h00;
			scan_rx_valid_o <= 1'b0;
			scan_par_err_o  <= 1'b0;
		end else if (ce_i) begin
			scan_rx_valid_o <= 1'b0;
			scan_par_err_o  <= 1'b0;
			if (scan_act & tck_rise) begin
				if (s2_r[2]) begin
					// Absent data is sent with a forced parity error
					scan_sh_r <= {par8(scan_cap_data_i) ^ ~scan_cap_valid_i,
					              scan_cap_data_i};
				end else if (s2_r[1]) begin
					scan_sh_r <= {s2_r[4], scan_sh_r[8:1]};
				end else if (s2_r[0]) begin
					// Latch only a frame whose parity checks
					if (scan_sh_r[8] == par8(scan_sh_r[7:0])) begin
						scan_rx_data_o  <= scan_sh_r[7:0];
						scan_rx_valid_o <= 1'b1;
					end else begin
						scan_par_err_o <= 1'b1;
					end
				end
			end
			// Output changes on the falling tap clock edge
			if (scan_act & tck_fall) begin
				scan_tdo_o <= scan_sh_r[0];
			end
		end
	end
endmodule

`default_nettype wire

/* File: dbgphy_defines.vh */
// Shared constants of the debug serial physical layer
`ifndef DBGPHY_DEFINES_VH
`define DBGPHY_DEFINES_VH

// Reference clock period
`define DBGPHY_CLK_NS        100
// Longest gap between debug clock edges before the link counts as inactive (5 kHz clock)
`define DBGPHY_IDLE_US       100
// Inactivity limit in reference clocks, rounded down
`define DBGPHY_IDLE_CYC      ((`DBGPHY_IDLE_US * 1000) / `DBGPHY_CLK_NS)
// Rising debug clock edges with data high that complete the enable sequence
`define DBGPHY_EN_CLKS       5'h10
// Low or high bit times that make a break or idle character
`define DBGPHY_BRK_BITS      4'hC
// Guard idle bits always inserted on a receive to transmit change
`define DBGPHY_GUARD_MIN     8'h02
// Usual guard length, what the controller should drive by default
`define DBGPHY_GUARD_DEF     8'h80
// Start, eight data, parity and two stop bits
`define DBGPHY_FRAME_BITS    4'hC
// Data bits per character and per scan frame
`define DBGPHY_DATA_BITS     8
// Communication register length on the scan path
`define DBGPHY_SCAN_BITS     9

`endif

/* File: dbgphy_asserts.sv */
// Port checker for the debug serial physical layer
`timescale 1ns/10ps
`default_nettype none
module dbgphy_asserts (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Watched ports
	input  wire logic debug_data_pin_o,
	input  wire logic debug_data_pin_oe_n_o,
	input  wire logic reset_pin_func_o,
	input  wire logic link_en_o,
	input  wire logic tx_mode_o,
	input  wire logic rx_valid_o,
	input  wire logic par_err_o,
	input  wire logic frame_err_o,
	input  wire logic break_o,
	input  wire logic collision_o,
	input  wire logic scan_fuse_i,
	input  wire logic scan_sw_dis_i,
	input  wire logic scan_en_o,
	input  wire logic scan_rx_valid_o,
	input  wire logic scan_par_err_o
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	//////////////////////////////////////////////////////////////////////////
	// Scan path usable only with fuse set and software disable clear
	property p_scan_en;
		scan_en_o == (scan_fuse_i & ~scan_sw_dis_i);
	endproperty
	a_scan_en: assert property (p_scan_en) else $error("scan enable");
	// A scan path disabled for four cycles reports no frame
	property p_scan_off;
		!scan_en_o [*4] |-> !scan_rx_valid_o && !scan_par_err_o;
	endproperty
	a_scan_off: assert property (p_scan_off) else $error("scan off");
	// A new bit value is always actively driven
	property p_drive;
		$changed(debug_data_pin_o) |-> !debug_data_pin_oe_n_o;
	endproperty
	a_drive: assert property (p_drive) else $error("undriven change");
	// Receive mode keeps the driver off
	property p_rx_oe;
		!tx_mode_o && !$past(tx_mode_o) |-> debug_data_pin_oe_n_o;
	endproperty
	a_rx_oe: assert property (p_rx_oe) else $error("driver in rx");
	// Collision drops back to receive for at least the next three cycles
	property p_coll;
		collision_o |=> !tx_mode_o [*3];
	endproperty
	a_coll: assert property (p_coll) else $error("tx after collision");
	// Breaks are reported only in receive mode
	property p_brk;
		break_o |-> !tx_mode_o;
	endproperty
	a_brk: assert property (p_brk) else $error("break in tx");
	// Good data never comes with an error
	property p_good;
		rx_valid_o |-> !par_err_o && !frame_err_o;
	endproperty
	a_good: assert property (p_good) else $error("data with error");
	// Reset function of the clock pin is off while the link runs
	property p_rstf;
		link_en_o |-> !reset_pin_func_o;
	endproperty
	a_rstf: assert property (p_rstf) else $error("reset pin live");
	// A disabled link neither sends nor delivers
	property p_off;
		!link_en_o |-> !tx_mode_o && !rx_valid_o;
	endproperty
	a_off: assert property (p_off) else $error("link off active");
	// Main scenarios reached
	c_rx: cover property (rx_valid_o);
	c_brk: cover property (break_o);
	c_coll: cover property (collision_o);
endmodule
bind dbgphy dbgphy_asserts dbgphy_asserts_i (.ref_clk_i, .rst_i,
	.debug_data_pin_o, .debug_data_pin_oe_n_o, .reset_pin_func_o,
	.link_en_o, .tx_mode_o, .rx_valid_o, .par_err_o, .frame_err_o,
	.break_o, .collision_o, .scan_fuse_i, .scan_sw_dis_i, .scan_en_o,
	.scan_rx_valid_o, .scan_par_err_o);
`default_nettype wire

/* File: dbgphy_prog.sv */
// Programmer model: debug clock and data pin, one bit at a time
`timescale 1ns/10ps
`default_nettype none
module dbgphy_prog (
	// Reference clock paces each bit
	input  wire logic ref_clk_i,
	// Level on the data pin
	input  wire logic pin_i,
	// Debug clock and data drive
	output var  logic clk_o,
	output var  logic drv_o,
	output var  logic drv_en_o
);
	// Clock rests high and stands still between calls
	initial begin
		clk_o = 1'b1;
		drv_o = 1'b1;
		drv_en_o = 1'b0;
	end
	//////////////////////////////////////////////////////////////////////////
	// Set the data drive without clocking
	task automatic level(input logic v, input logic en);
		@(posedge ref_clk_i);
		drv_o <= v;
		drv_en_o <= en;
	endtask
	// One 800 ns bit: change on the fall, sample on the rise
	task automatic bitx(input logic d, input logic en, output logic s);
		@(posedge ref_clk_i);
		clk_o <= 1'b0;
		drv_o <= d;
		drv_en_o <= en;
		repeat (4) @(posedge ref_clk_i);
		clk_o <= 1'b1;
		s = pin_i;
		repeat (3) @(posedge ref_clk_i);
	endtask
	// n bit times of one level, for enable, idle and break
	task automatic hold(input logic v, input int n, input logic en);
		logic s;
		for (int i = 0; i < n; i++)
			bitx(v, en, s);
	endtask
	// Character with optional bad parity or low first stop bit
	task automatic send(input logic [7:0] d, input logic pf, input logic sb);
		logic s;
		logic [11:0] f;
		f = {1'b1, ~sb, ^d ^ pf, d, 1'b0};
		for (int i = 0; i < 12; i++)
			bitx(f[i], 1'b1, s);
	endtask
	// Released pin: count high bits, then take the rest of a frame
	task automatic recv(output logic [10:0] f, output int n);
		logic s;
		s = 1'b1;
		n = 0;
		while (s !== 1'b0 && n < 200) begin
			bitx(1'b1, 1'b0, s);
			if (s !== 1'b0)
				n++;
		end
		for (int i = 0; i < 11; i++)
			bitx(1'b1, 1'b0, f[i]);
	endtask
endmodule
`default_nettype wire

/* File: dbgphy_tb.sv */
// Self-checking bench for the debug serial physical layer
`timescale 1ns/10ps
`default_nettype none
module dbgphy_tb;
	logic       ref_clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       dir_tx_i = 1'b0;
	logic       tx_valid_i = 1'b0;
	logic [7:0] tx_data_i = 8'h00;
	logic [7:0] guard_bits_i = 8'h00;
	logic       scan_fuse_i = 1'b1;
	logic       scan_sw_dis_i = 1'b0;
	logic       scan_ir_comm_i = 1'b0;
	logic       scan_tck_i = 1'b0;
	logic       scan_tdi_i = 1'b0;
	logic       scan_capture_i = 1'b0;
	logic       scan_shift_i = 1'b0;
	logic       scan_update_i = 1'b0;
	logic [7:0] scan_cap_data_i = 8'h5A;
	logic       scan_cap_valid_i = 1'b1;
	logic       keep_r = 1'b1;
	logic       reset_fuse_off_i = 1'b0;
	wire        clk_w, drv_w, den_w, pin_w, dq_w, oe_w, rpf_w, len_w;
	wire        txm_w, rdy_w, rxv_w, pe_w, fe_w, bk_w, co_w, tdo_w;
	wire        sen_w, sv_w, sp_w;
	wire  [7:0] rxd_w, srd_w;
	int failures = 0, compares = 0, cyc = 0;
	int n_rx = 0, n_pe = 0, n_fe = 0, n_bk = 0, n_co = 0, n_sv = 0, n_sp = 0;
	dbgphy #(.RST_MIN_CYC(16'h0004), .IDLE_CYC(200)) dbgphy_i (
		.ref_clk_i, .rst_i, .ce_i(1'b1), .debug_clock_pin_i(clk_w),
		.debug_data_pin_i(pin_w), .debug_data_pin_o(dq_w),
		.debug_data_pin_oe_n_o(oe_w), .reset_pin_func_o(rpf_w),
		.reset_fuse_off_i, .guard_bits_i, .link_en_o(len_w),
		.tx_mode_o(txm_w), .dir_tx_i, .tx_data_i, .tx_valid_i,
		.tx_ready_o(rdy_w), .rx_data_o(rxd_w), .rx_valid_o(rxv_w),
		.par_err_o(pe_w), .frame_err_o(fe_w), .break_o(bk_w),
		.collision_o(co_w), .scan_fuse_i, .scan_sw_dis_i, .scan_ir_comm_i,
		.scan_tck_i, .scan_tdi_i, .scan_capture_i, .scan_shift_i,
		.scan_update_i, .scan_tdo_o(tdo_w), .scan_en_o(sen_w),
		.scan_cap_data_i, .scan_cap_valid_i, .scan_rx_data_o(srd_w),
		.scan_rx_valid_o(sv_w), .scan_par_err_o(sp_w));
	dbgphy_prog dbgphy_prog_i (.ref_clk_i, .pin_i(pin_w), .clk_o(clk_w),
		.drv_o(drv_w), .drv_en_o(den_w));
	// Low wins on contention; the keeper holds an undriven pin
	assign pin_w = (!oe_w | den_w) ?
		((oe_w | dq_w) & (!den_w | drv_w)) : keep_r;
	// 100 ns clock
	always #50 ref_clk_i = ~ref_clk_i;
	// Keeper, pulse counters and hang limit
	always @(posedge ref_clk_i) begin
		keep_r <= pin_w;
		cyc++;
		n_rx += (rxv_w === 1'b1);
		n_pe += (pe_w === 1'b1);
		n_fe += (fe_w === 1'b1);
		n_bk += (bk_w === 1'b1);
		n_co += (co_w === 1'b1);
		n_sv += (sv_w === 1'b1);
		n_sp += (sp_w === 1'b1);
		if (cyc == 20000) begin
			failures++;
			finish_test;
		end
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One tck period; tdo is settled five cycles after the fall
	task automatic tck(input logic d, output logic s);
		@(posedge ref_clk_i);
		scan_tck_i <= 1'b0;
		scan_tdi_i <= d;
		repeat (5) @(posedge ref_clk_i);
		scan_tck_i <= 1'b1;
		s = tdo_w;
		repeat (5) @(posedge ref_clk_i);
	endtask
	// Capture, nine shifts LSB first, update
	task automatic scan(input logic [8:0] din, output logic [8:0] dout);
		logic s;
		scan_capture_i <= 1'b1;
		tck(1'b0, s);
		scan_capture_i <= 1'b0;
		scan_shift_i <= 1'b1;
		for (int i = 0; i < 9; i++)
			tck(din[i], dout[i]);
		scan_shift_i <= 1'b0;
		scan_update_i <= 1'b1;
		tck(1'b0, s);
		scan_update_i <= 1'b0;
	endtask
	task automatic t_reset;
		@(negedge ref_clk_i);
		chk(16'({len_w, txm_w, oe_w, dq_w, rdy_w, rpf_w}), 16'h000F);
	endtask
	task automatic t_enable;
		dbgphy_prog_i.level(1'b1, 1'b1);
		repeat (10) @(negedge ref_clk_i);
		chk(16'(rpf_w), 16'h0000);
		dbgphy_prog_i.hold(1'b1, 15, 1'b1);
		@(negedge ref_clk_i);
		chk(16'(len_w), 16'h0000);
		dbgphy_prog_i.hold(1'b1, 2, 1'b1);
		@(negedge ref_clk_i);
		chk(16'({len_w, txm_w}), 16'h0002);
	endtask
	task automatic t_rx;
		dbgphy_prog_i.send(8'hA5, 1'b0, 1'b0);
		dbgphy_prog_i.send(8'h3C, 1'b1, 1'b0);
		dbgphy_prog_i.send(8'h81, 1'b0, 1'b1);
		dbgphy_prog_i.hold(1'b1, 1, 1'b1);
		@(negedge ref_clk_i);
		chk(16'(n_rx * 256 + n_pe * 16 + n_fe), 16'h0111);
		chk(16'(rxd_w), 16'h00A5);
	endtask
	task automatic t_break;
		dbgphy_prog_i.hold(1'b0, 12, 1'b1);
		dbgphy_prog_i.hold(1'b1, 2, 1'b1);
		@(negedge ref_clk_i);
		chk(16'(n_bk), 16'h0001);
	endtask
	task automatic t_tx;
		logic [10:0] f;
		logic [7:0] d;
		int n;
		@(posedge ref_clk_i);
		tx_valid_i <= 1'b1;
		tx_data_i <= 8'h01;
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk_i);
			tx_data_i <= tx_data_i + 8'h21;
		end
		tx_valid_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(16'(rdy_w), 16'h0000);
		@(posedge ref_clk_i);
		dir_tx_i <= 1'b1;
		d = 8'h01;
		for (int i = 0; i < 8; i++) begin
			dbgphy_prog_i.recv(f, n);
			if (i == 0)
				chk(16'(n), 16'h0002);
			chk(16'(f), 16'({2'b11, ^d, d}));
			d = d + 8'h21;
		end
		dir_tx_i <= 1'b0;
		dbgphy_prog_i.hold(1'b1, 3, 1'b0);
		@(negedge ref_clk_i);
		chk(16'({txm_w, oe_w, rdy_w}), 16'h0003);
	endtask
	task automatic t_coll;
		@(posedge ref_clk_i);
		guard_bits_i <= 8'h80;
		tx_valid_i <= 1'b1;
		dir_tx_i <= 1'b1;
		@(posedge ref_clk_i);
		tx_valid_i <= 1'b0;
		dbgphy_prog_i.hold(1'b0, 12, 1'b1);
		dir_tx_i <= 1'b0;
		dbgphy_prog_i.hold(1'b1, 1, 1'b1);
		dbgphy_prog_i.hold(1'b0, 12, 1'b1);
		dbgphy_prog_i.hold(1'b1, 2, 1'b1);
		@(negedge ref_clk_i);
		chk(16'(n_co * 16 + n_bk), 16'h0012);
		chk(16'(txm_w), 16'h0000);
	endtask
	task automatic t_scan;
		logic [8:0] q;
		@(posedge ref_clk_i);
		scan_ir_comm_i <= 1'b1;
		scan({^8'hC3, 8'hC3}, q);
		chk(16'(q), 16'({^8'h5A, 8'h5A}));
		chk(16'(srd_w), 16'h00C3);
		scan_cap_valid_i <= 1'b0;
		scan({~^8'hC3, 8'hC3}, q);
		chk(16'(q), 16'({~^8'h5A, 8'h5A}));
		scan_sw_dis_i <= 1'b1;
		scan({^8'h3C, 8'h3C}, q);
		@(negedge ref_clk_i);
		chk(16'(n_sv * 16 + n_sp), 16'h0011);
	endtask
	// Data is dropped first: a high data pin would arm the link again
	task automatic t_idle;
		@(negedge ref_clk_i);
		chk(16'({len_w, rpf_w}), 16'h0002);
		dbgphy_prog_i.level(1'b0, 1'b1);
		repeat (250) @(negedge ref_clk_i);
		chk(16'({len_w, rpf_w}), 16'h0001);
		@(posedge ref_clk_i);
		reset_fuse_off_i <= 1'b1;
		@(negedge ref_clk_i);
		chk(16'(rpf_w), 16'h0000);
		@(posedge ref_clk_i);
		reset_fuse_off_i <= 1'b0;
	endtask
	// Reset for five cycles, then the scenarios in order
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_enable;
		t_rx;
		t_break;
		t_tx;
		t_coll;
		t_idle;
		t_scan;
		finish_test;
	end
endmodule
`default_nettype wire
